// *** logic/current_limit_fault_timer_regs.vh ***
// Purpose: Constants for the current-limit fault timer block
// Assumes: 125 MHz system clock, 8-bit command codes and data
// Notes: Times are kept in ms; cycle counts derive from CLK_KHZ
//
// Behaviour
// - One shared 8-bit timing register at 16h, resets zero
// - Foldback bit clear uses nominal 60 ms, ignores selection
// - Count up after inrush, while limiting at limit
// - Counter reaching timeout switches channel power off
// - Timeout starts one-second cool-down, blocks turn-on
// - Below limit, decrement at 1/16 rate, floor zero
// - Clear counter on any channel turn-off event
// - Selection change resets running timer, new duration
// - Semiauto cool-down end restarts detection if enabled
// - Reset or off/manual mode cancels cool-down
// - Foldback set uses selection, code 00 gives 58 ms
`ifndef CURRENT_LIMIT_FAULT_TIMER_REGS_VH
`define CURRENT_LIMIT_FAULT_TIMER_REGS_VH

// ==========================================================
// Register map
`define FAULT_TIMING_SETUP_CODE 8'h16
`define FAULT_TIMING_SETUP_RESET 8'h00
`define UNMAPPED_READ_VALUE 8'h00

// ==========================================================
// Field positions
`define LIM_SEL_HI 7
`define LIM_SEL_LO 6
`define INRUSH_SEL_HI 5
`define INRUSH_SEL_LO 4
`define OVLD_SEL_HI 3
`define OVLD_SEL_LO 2
`define DISC_SEL_HI 1
`define DISC_SEL_LO 0

// ==========================================================
// Timing
`define CLK_KHZ 125000
`define LIM_NOMINAL_MS 60
`define LIM_SEL0_MS 58
`define LIM_SEL1_MS 15
`define LIM_SEL2_MS 10
`define LIM_SEL3_MS 6
`define COOLDOWN_MS 1000
`define DECAY_DIV_LAST 4'hF

`endif

// *** logic/limit_channel_timer.v ***
// Purpose: One channel of current-limit fault timing and cool-down
// Assumes: All inputs synchronous to sys_clk_i
// Notes: limit_cyc_i must be at least one
module limit_channel_timer #(
  parameter integer CNT_W = 27,
  parameter integer COOL_CYC = 125000000
) (
  input wire sys_clk_i, // System clock
  input wire rstn_i, // Async reset, active low
  input wire decay_tick_i, // One pulse per 16 cycles
  input wire [CNT_W-1:0] limit_cyc_i, // Selected timeout in cycles
  input wire limiting_i, // Channel held at current limit
  input wire inrush_done_i, // Inrush window has expired
  input wire clear_i, // Channel turned off by an event
  input wire sel_change_i, // Limit time selection rewritten
  input wire cancel_cool_i, // Reset command or off/manual mode
  input wire semiauto_i, // Channel in semiautomatic mode
  input wire detect_enable_i, // Detect enable bit of channel
  output reg [CNT_W-1:0] fault_count_o, // Fault counter value
  output reg fault_off_o, // Pulse: power channel off
  output reg cooling_o, // Cool-down running, turn-on refused
  output reg detect_restart_o // Pulse: start a detection cycle
);

localparam integer COOL_LAST_INT = COOL_CYC - 1;
localparam [CNT_W-1:0] COOL_LAST = COOL_LAST_INT[CNT_W-1:0];
localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

reg [CNT_W-1:0] cool_cnt;

// ==========================================================
// Fault counter
always @(posedge sys_clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    fault_count_o <= {CNT_W{1'b0}};
    fault_off_o <= 1'b0;
  end
  else
  begin
    fault_off_o <= 1'b0;
    if (clear_i || sel_change_i)
      fault_count_o <= {CNT_W{1'b0}};
    // Channel is already off in the cycle of the off pulse, so nothing counts then
    else if (!cooling_o && !fault_off_o && limiting_i && inrush_done_i)
    begin
      if (fault_count_o >= limit_cyc_i - ONE)
      begin
        fault_count_o <= {CNT_W{1'b0}};
        fault_off_o <= 1'b1;
      end
      else
        fault_count_o <= fault_count_o + ONE;
    end
    else if (!cooling_o && !limiting_i && decay_tick_i && fault_count_o != {CNT_W{1'b0}})
      fault_count_o <= fault_count_o - ONE;
  end
end

// ==========================================================
// Cool-down timer
always @(posedge sys_clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    cooling_o <= 1'b0;
    cool_cnt <= {CNT_W{1'b0}};
    detect_restart_o <= 1'b0;
  end
  else
  begin
    detect_restart_o <= 1'b0;
    if (cancel_cool_i)
    begin
      cooling_o <= 1'b0;
      cool_cnt <= {CNT_W{1'b0}};
    end
    else if (fault_off_o)
    begin
      cooling_o <= 1'b1;
      cool_cnt <= {CNT_W{1'b0}};
    end
    else if (cooling_o)
    begin
      if (cool_cnt == COOL_LAST)
      begin
        cooling_o <= 1'b0;
        detect_restart_o <= semiauto_i & detect_enable_i;
      end
      else
        cool_cnt <= cool_cnt + ONE;
    end
  end
end

endmodule // limit_channel_timer

// *** logic/current_limit_fault_timer.v ***
// Purpose: Shared timing register and per-channel current-limit fault timers
// Assumes: Command port and channel status are on sys_clk_i; shutdown pin is not
// Notes: Inrush, overload and disconnect fields are stored and exported only
//        A limit field change restarts the fault counters of every channel
//        Fast shutdown clears counters but never cancels a cool-down
`include "current_limit_fault_timer_regs.vh"
module current_limit_fault_timer #(
  parameter integer NUM_CH = 4,
  parameter integer CNT_W = 27,
  parameter integer LIM_NOMINAL_CYC = `LIM_NOMINAL_MS * `CLK_KHZ,
  parameter integer LIM_SEL0_CYC = `LIM_SEL0_MS * `CLK_KHZ,
  parameter integer LIM_SEL1_CYC = `LIM_SEL1_MS * `CLK_KHZ,
  parameter integer LIM_SEL2_CYC = `LIM_SEL2_MS * `CLK_KHZ,
  parameter integer LIM_SEL3_CYC = `LIM_SEL3_MS * `CLK_KHZ,
  parameter integer COOL_CYC = `COOLDOWN_MS * `CLK_KHZ
) (
  input wire sys_clk_i, // System clock, 125 MHz
  input wire rstn_i, // Async reset, active low
  input wire cmd_wr_i, // Command write strobe
  input wire cmd_rd_i, // Command read strobe
  input wire [7:0] cmd_code_i, // Command code
  input wire [7:0] cmd_wdata_i, // Command write data
  output reg [7:0] cmd_rdata_o, // Command read data
  output reg cmd_rvalid_o, // Read data valid pulse
  input wire [NUM_CH-1:0] double_foldback_enable_i, // Per-channel foldback bits
  input wire [NUM_CH-1:0] current_limit_level_i, // Channel limiting at limit
  input wire [NUM_CH-1:0] inrush_done_i, // Inrush window expired
  input wire [NUM_CH-1:0] power_off_cmd_i, // Power enable turn-off pulse
  input wire [NUM_CH-1:0] reset_cmd_i, // Reset command pulse
  input wire [NUM_CH-1:0] dc_disconnect_i, // DC disconnect event pulse
  input wire fast_shutdown_input_i, // Fast shutdown pin, async
  input wire [NUM_CH-1:0] shutdown_select_i, // Channels shed by fast shutdown
  input wire [NUM_CH-1:0] mode_off_manual_i, // Pulse: mode set to off or manual
  input wire [NUM_CH-1:0] semiauto_i, // Channel in semiautomatic mode
  input wire [NUM_CH-1:0] detect_enable_i, // Detect enable bits
  output wire [1:0] limit_fault_time_select_o, // Limit time field
  output wire [1:0] inrush_fault_time_select_o, // Inrush time field
  output wire [1:0] overload_fault_time_select_o, // Overload time field
  output wire [1:0] disconnect_hold_time_select_o, // Disconnect hold field
  output wire [NUM_CH-1:0] limit_fault_off_o, // Pulse: turn channel off
  output wire [NUM_CH-1:0] cooldown_active_o, // Turn-on refused while high
  output wire [NUM_CH-1:0] detect_restart_o, // Pulse: restart detection
  output wire [NUM_CH*CNT_W-1:0] fault_count_o // Fault counters, channel 0 low
);

// Timeouts cut to the counter width on purpose; the defaults fit it
localparam [CNT_W-1:0] NOM_CYC = LIM_NOMINAL_CYC[CNT_W-1:0];
localparam [CNT_W-1:0] SEL0_CYC = LIM_SEL0_CYC[CNT_W-1:0];
localparam [CNT_W-1:0] SEL1_CYC = LIM_SEL1_CYC[CNT_W-1:0];
localparam [CNT_W-1:0] SEL2_CYC = LIM_SEL2_CYC[CNT_W-1:0];
localparam [CNT_W-1:0] SEL3_CYC = LIM_SEL3_CYC[CNT_W-1:0];

reg [7:0] fault_timing_setup;
reg lim_sel_change;
reg shut_meta;
reg shut_sync;
reg [3:0] decay_div;
reg decay_tick;

wire setup_hit;
wire setup_wr;
wire [1:0] next_lim_sel;

// ==========================================================
// Timing register
assign setup_hit = (cmd_code_i == `FAULT_TIMING_SETUP_CODE);
assign setup_wr = cmd_wr_i && setup_hit;
assign next_lim_sel = cmd_wdata_i[`LIM_SEL_HI:`LIM_SEL_LO];

always @(posedge sys_clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    fault_timing_setup <= `FAULT_TIMING_SETUP_RESET;
    lim_sel_change <= 1'b0;
  end
  else
  begin
    lim_sel_change <= 1'b0;
    if (setup_wr)
    begin
      fault_timing_setup <= cmd_wdata_i;
      // Rewriting the same limit field leaves running timers alone
      lim_sel_change <= (next_lim_sel != limit_fault_time_select_o);
    end
  end
end

// ==========================================================
// Read path
// A read in the cycle of a write returns the old value
always @(posedge sys_clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    cmd_rdata_o <= 8'h00;
    cmd_rvalid_o <= 1'b0;
  end
  else
  begin
    cmd_rvalid_o <= cmd_rd_i;
    if (cmd_rd_i)
    begin
      if (setup_hit)
        cmd_rdata_o <= fault_timing_setup;
      else
        cmd_rdata_o <= `UNMAPPED_READ_VALUE;
    end
  end
end

assign limit_fault_time_select_o = fault_timing_setup[`LIM_SEL_HI:`LIM_SEL_LO];
assign inrush_fault_time_select_o = fault_timing_setup[`INRUSH_SEL_HI:`INRUSH_SEL_LO];
assign overload_fault_time_select_o = fault_timing_setup[`OVLD_SEL_HI:`OVLD_SEL_LO];
assign disconnect_hold_time_select_o = fault_timing_setup[`DISC_SEL_HI:`DISC_SEL_LO];

// ==========================================================
// Fast shutdown pin synchroniser
// Only shut_sync feeds logic; shut_meta may still be settling
always @(posedge sys_clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    shut_meta <= 1'b0;
    shut_sync <= 1'b0;
  end
  else
  begin
    shut_meta <= fast_shutdown_input_i;
    shut_sync <= shut_meta;
  end
end

// ==========================================================
// Decrement rate divider, one pulse per sixteen cycles
// One shared phase: every channel decays on the same tick
always @(posedge sys_clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    decay_div <= 4'h0;
    decay_tick <= 1'b0;
  end
  else
  begin
    decay_div <= decay_div + 4'h1;
    decay_tick <= (decay_div == `DECAY_DIV_LAST);
  end
end

// ==========================================================
// Channels
genvar ch;
generate
  for (ch = 0; ch < NUM_CH; ch = ch + 1)
  begin : g_ch
    reg [CNT_W-1:0] limit_cyc;
    wire clear;
    wire cancel_cool;

    // Foldback bit picks between nominal time and the selection table
    always @*
    begin
      limit_cyc = NOM_CYC;
      if (double_foldback_enable_i[ch])
      begin
        case (limit_fault_time_select_o)
          2'h0: limit_cyc = SEL0_CYC;
          2'h1: limit_cyc = SEL1_CYC;
          2'h2: limit_cyc = SEL2_CYC;
          2'h3: limit_cyc = SEL3_CYC;
          default: limit_cyc = NOM_CYC;
        endcase
      end
    end

    // Fast shutdown clears the counter but leaves the cool-down running
    assign clear = power_off_cmd_i[ch] | reset_cmd_i[ch] | dc_disconnect_i[ch] |
                   (shut_sync & shutdown_select_i[ch]);
    assign cancel_cool = reset_cmd_i[ch] | mode_off_manual_i[ch];

    limit_channel_timer #(
      .CNT_W(CNT_W),
      .COOL_CYC(COOL_CYC)
    ) u_timer (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .decay_tick_i(decay_tick),
      .limit_cyc_i(limit_cyc),
      .limiting_i(current_limit_level_i[ch]),
      .inrush_done_i(inrush_done_i[ch]),
      .clear_i(clear),
      .sel_change_i(lim_sel_change),
      .cancel_cool_i(cancel_cool),
      .semiauto_i(semiauto_i[ch]),
      .detect_enable_i(detect_enable_i[ch]),
      .fault_count_o(fault_count_o[ch*CNT_W +: CNT_W]),
      .fault_off_o(limit_fault_off_o[ch]),
      .cooling_o(cooldown_active_o[ch]),
      .detect_restart_o(detect_restart_o[ch])
    );
  end
endgenerate

endmodule // current_limit_fault_timer

// *** dv/current_limit_fault_timer_sva.sv ***
// Purpose: Port checks for the current-limit fault timer
// Assumes: Timer traffic runs on channel 0
// Notes: Bound to the top module
module current_limit_fault_timer_sva #(
  parameter integer NUM_CH = 4,
  parameter integer CNT_W = 27
) (
  input logic sys_clk_i,
  input logic rstn_i,
  input logic cmd_wr_i,
  input logic cmd_rd_i,
  input logic [7:0] cmd_code_i,
  input logic [7:0] cmd_wdata_i,
  input logic [7:0] cmd_rdata_o,
  input logic cmd_rvalid_o,
  input logic [NUM_CH-1:0] current_limit_level_i,
  input logic [NUM_CH-1:0] inrush_done_i,
  input logic [NUM_CH-1:0] power_off_cmd_i,
  input logic [NUM_CH-1:0] reset_cmd_i,
  input logic [NUM_CH-1:0] dc_disconnect_i,
  input logic [NUM_CH-1:0] mode_off_manual_i,
  input logic [1:0] limit_fault_time_select_o,
  input logic [NUM_CH-1:0] limit_fault_off_o,
  input logic [NUM_CH-1:0] cooldown_active_o,
  input logic [NUM_CH*CNT_W-1:0] fault_count_o
);
  logic [CNT_W-1:0] cnt;
  assign cnt = fault_count_o[CNT_W-1:0];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // ====
  // Command port
  AST_RD_MAP: assert property (cmd_rd_i && cmd_code_i == 8'h16 |=>
    cmd_rvalid_o && cmd_rdata_o[7:6] == $past(limit_fault_time_select_o)) else $error("bad read");
  AST_RD_UNMAP: assert property (cmd_rd_i && cmd_code_i != 8'h16 |=>
    cmd_rvalid_o && cmd_rdata_o == 8'h00) else $error("bad unmapped read");
  AST_WR_SEL: assert property (cmd_wr_i && cmd_code_i == 8'h16 |=>
    limit_fault_time_select_o == $past(cmd_wdata_i[7:6])) else $error("write lost");
  // ====
  // Channel 0 timer
  AST_NO_UP: assert property (!(current_limit_level_i[0] && inrush_done_i[0]) |=>
    cnt <= $past(cnt)) else $error("count rose");
  AST_DECAY: assert property (cnt + 1 == $past(cnt) |=> cnt + 1 != $past(cnt))
    else $error("decay too fast");
  AST_OFF_COOL: assert property (limit_fault_off_o[0] |=> cooldown_active_o[0])
    else $error("no cool-down");
  AST_COOL_HOLD: assert property (cooldown_active_o[0] && $past(cooldown_active_o[0]) |->
    cnt <= $past(cnt)) else $error("count in cool-down");
  AST_CLEAR: assert property (power_off_cmd_i[0] || reset_cmd_i[0] || dc_disconnect_i[0] |=>
    cnt == 0) else $error("not cleared");
  AST_CANCEL: assert property (reset_cmd_i[0] || mode_off_manual_i[0] |=>
    !cooldown_active_o[0]) else $error("not cancelled");
  AST_SEL_CHG: assert property (cmd_wr_i && cmd_code_i == 8'h16 &&
    cmd_wdata_i[7:6] != limit_fault_time_select_o |-> ##[1:2] cnt == 0) else $error("no restart");
  COV_OFF: cover property (limit_fault_off_o[0]);
  COV_COOL_END: cover property ($fell(cooldown_active_o[0]));
  COV_DECAY: cover property (cnt + 1 == $past(cnt));
endmodule // current_limit_fault_timer_sva

bind current_limit_fault_timer current_limit_fault_timer_sva #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) i_sva (
  .sys_clk_i, .rstn_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i, .cmd_wdata_i, .cmd_rdata_o, .cmd_rvalid_o,
  .current_limit_level_i, .inrush_done_i, .power_off_cmd_i, .reset_cmd_i, .dc_disconnect_i,
  .mode_off_manual_i, .limit_fault_time_select_o, .limit_fault_off_o, .cooldown_active_o, .fault_count_o
);

// *** dv/cmd_host.sv ***
// Purpose: Host side of the command port
// Assumes: Strobes are one cycle wide
// Notes: Idle code and data lines carry the inverse of the last value
module cmd_host (
  input wire logic clk_i, // System clock
  input wire logic [7:0] rdata_i, // Read data
  output logic wr_o, // Write strobe
  output logic rd_o, // Read strobe
  output logic [7:0] code_o, // Command code
  output logic [7:0] data_o // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    code_o = 8'h00;
    data_o = 8'h00;
  end
  task automatic put(input logic w, input logic [7:0] c, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    wr_o = w;
    rd_o = !w;
    code_o = c;
    data_o = d;
    @(posedge clk_i);
    #1;
    q = rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    code_o = ~c;
    data_o = ~d;
  endtask
endmodule // cmd_host

// *** dv/current_limit_fault_timer_tb.sv ***
// Purpose: Self-checking bench for the current-limit fault timer
// Assumes: Short timing parameters, traffic on channel 0
// Notes: Stimulus changes 1 ns after the rising edge
module current_limit_fault_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer LN = 40, L0 = 30, L1 = 20, L2 = 10, L3 = 5, LC = 50;
  logic clk = 1'b0, rstn = 1'b0, fsd = 1'b0, wr, rd, rvalid;
  logic [7:0] code, wdata, rdata, q;
  logic [3:0] dfb = 4'h0, lim = 4'h0, inr = 4'hF, poff = 4'h0, rcmd = 4'h0, dcd = 4'h0, mom = 4'h0;
  logic [3:0] ssel = 4'h1, semi = 4'hF, det = 4'hF, off, cool, rsd;
  logic [1:0] s_lim, s_inr, s_ovl, s_dis;
  logic [107:0] cnt;
  int n_fail = 0, n_checks = 0, n, m;
  int lt[4] = '{L0, L1, L2, L3};
  always #4 clk = ~clk;
  current_limit_fault_timer #(.LIM_NOMINAL_CYC(LN), .LIM_SEL0_CYC(L0), .LIM_SEL1_CYC(L1),
    .LIM_SEL2_CYC(L2), .LIM_SEL3_CYC(L3), .COOL_CYC(LC)) i_dut (
    .sys_clk_i(clk), .rstn_i(rstn), .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_code_i(code),
    .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid), .double_foldback_enable_i(dfb),
    .current_limit_level_i(lim), .inrush_done_i(inr), .power_off_cmd_i(poff), .reset_cmd_i(rcmd),
    .dc_disconnect_i(dcd), .fast_shutdown_input_i(fsd), .shutdown_select_i(ssel),
    .mode_off_manual_i(mom), .semiauto_i(semi), .detect_enable_i(det),
    .limit_fault_time_select_o(s_lim), .inrush_fault_time_select_o(s_inr),
    .overload_fault_time_select_o(s_ovl), .disconnect_hold_time_select_o(s_dis),
    .limit_fault_off_o(off), .cooldown_active_o(cool), .detect_restart_o(rsd), .fault_count_o(cnt));
  cmd_host i_host (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .code_o(code), .data_o(wdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Holds channel 0 at the limit until switched off, returns edges taken
  task automatic run_to_off(output int e);
    lim[0] = 1'b1;
    e = 0;
    while (off[0] !== 1'b1 && e < 200)
    begin
      cyc(1);
      e++;
    end
  endtask
  // Keeps limiting through the cool-down, counts its length and restarts
  task automatic cool_out(output int e, output int r);
    e = 0;
    r = 0;
    cyc(1);
    while (cool[0] === 1'b1 && e < 200)
    begin
      cyc(1);
      e++;
      r += (rsd[0] === 1'b1);
    end
    chk(cnt[26:0], 0, "count in cool-down");
    lim[0] = 1'b0;
    cyc(1);
    r += (rsd[0] === 1'b1);
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #160000;
    n_fail++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    i_host.put(0, 8'h16, 8'h00, q);
    chk(q, 8'h00, "reset value");
    chk(rvalid, 1'b1, "read valid");
    i_host.put(1, 8'h16, 8'hA5, q);
    i_host.put(1, 8'h17, 8'h3C, q);
    i_host.put(0, 8'h16, 8'h00, q);
    chk(q, 8'hA5, "readback");
    chk({s_lim, s_inr, s_ovl, s_dis}, 8'hA5, "fields");
    i_host.put(0, 8'h17, 8'h00, q);
    chk(q, 8'h00, "unmapped");
    run_to_off(n);
    chk(n, LN, "nominal timeout");
    cool_out(n, m);
    chk(n == LC || n == LC + 1, 1, "cool length");
    chk(m, 1, "restart");
    dfb[0] = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      semi[0] = (k != 2);
      det[0] = (k != 3);
      i_host.put(1, 8'h16, 8'(k << 6), q);
      cyc(1);
      run_to_off(n);
      chk(n, lt[k], "select timeout");
      cool_out(n, m);
      chk(m, k < 2, "restart gating");
    end
    semi[0] = 1'b1;
    det[0] = 1'b1;
    i_host.put(1, 8'h16, 8'h00, q);
    lim[0] = 1'b1;
    cyc(10);
    i_host.put(1, 8'h16, 8'h40, q);
    run_to_off(n);
    chk(n, L1 + 1, "restart on new select");
    cool_out(n, m);
    dfb[0] = 1'b0;
    inr[0] = 1'b0;
    lim[0] = 1'b1;
    cyc(20);
    chk(cnt[26:0], 0, "count in inrush");
    inr[0] = 1'b1;
    cyc(8);
    lim[0] = 1'b0;
    chk(cnt[26:0], 8, "count up");
    cyc(100);
    chk(cnt[26:0] == 1 || cnt[26:0] == 2, 1, "decay rate");
    cyc(40);
    chk(cnt[26:0], 0, "decay floor");
    for (int k = 0; k < 4; k++)
    begin
      lim[0] = 1'b1;
      cyc(8);
      lim[0] = 1'b0;
      {fsd, dcd[0], rcmd[0], poff[0]} = 4'b0001 << k;
      cyc(4);
      {fsd, dcd[0], rcmd[0], poff[0]} = 4'b0000;
      chk(cnt[26:0], 0, "clear on turn-off");
    end
    for (int k = 0; k < 2; k++)
    begin
      run_to_off(n);
      lim[0] = 1'b0;
      cyc(5);
      {rcmd[0], mom[0]} = 2'b01 << k;
      cyc(1);
      {rcmd[0], mom[0]} = 2'b00;
      chk(cool[0], 1'b0, "cancel");
      m = 0;
      repeat (LC + 5)
      begin
        cyc(1);
        m += (rsd[0] === 1'b1);
      end
      chk(m, 0, "restart after cancel");
    end
    give_verdict();
  end
endmodule // current_limit_fault_timer_tb
